// ### ssp_pkg.sv
// shared constants and types for the simplified spi master channel
package ssp_pkg;

  // register byte offsets on the axi4-lite port
  localparam int unsigned ADDR_W = 6;
  localparam logic [5:0] OFF_DATA = 6'h00;
  localparam logic [5:0] OFF_MODE = 6'h04;
  localparam logic [5:0] OFF_COMM = 6'h08;
  localparam logic [5:0] OFF_STAT = 6'h0c;
  localparam logic [5:0] OFF_FCLR = 6'h10;
  localparam logic [5:0] OFF_START = 6'h14;
  localparam logic [5:0] OFF_STOP = 6'h18;
  localparam logic [5:0] OFF_OUTEN = 6'h1c;
  localparam logic [5:0] OFF_OLVL = 6'h20;
  localparam logic [5:0] OFF_PRESC = 6'h24;

  // field positions
  localparam int unsigned DATA_DIV_LSB = 9;
  localparam int unsigned COMM_DAP = 0;
  localparam int unsigned COMM_CKP = 1;
  localparam int unsigned COMM_LSB = 2;
  localparam int unsigned COMM_LEN8 = 3;
  localparam int unsigned STAT_OVF = 0;
  localparam int unsigned STAT_BFF = 5;
  localparam int unsigned STAT_BUSY = 6;
  localparam int unsigned OLVL_DATA = 0;
  localparam int unsigned OLVL_CLK = 1;

  // reset values
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic OLVL_DATA_RST = 1'b1;
  localparam logic OLVL_CLK_RST = 1'b1;
  localparam logic SCK_IDLE = 1'b1;

  // frame lengths and axi answers
  localparam logic [3:0] LEN_SHORT = 4'h7;
  localparam logic [3:0] LEN_LONG = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic len8;
    logic lsb_first;
    logic clock_polarity_sel;
    logic data_phase_sel;
  } ssp_cfg_s;

  localparam ssp_cfg_s CFG_RST = '{len8: 1'b1, lsb_first: 1'b0,
                                   clock_polarity_sel: 1'b0, data_phase_sel: 1'b0};

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LEAD = 2'b01,
    ST_SHIFT = 2'b11
  } ssp_state_e;

endpackage : ssp_pkg

// ### ssp_clk_div.sv
// operation clock prescaler and transfer clock half-period divider
`timescale 1ns/1ps
module ssp_clk_div #(
  parameter int unsigned PRE_W = 4,
  parameter int unsigned DIV_W = 7
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic run_i,
  input wire logic [PRE_W-1:0] presc_i,
  input wire logic [DIV_W-1:0] div_i,
  // half-period enable
  output logic tick_o
);

  localparam int unsigned PCNT_W = (1 << PRE_W) - 1;

  logic [PCNT_W-1:0] pcnt_q;
  logic [DIV_W-1:0] dcnt_q;
  logic [PCNT_W-1:0] mask;
  logic mck_en;

  // mask of the low presc bits; all ones there marks one operation clock
  assign mask = PCNT_W'((PCNT_W+1)'(1) << presc_i) - PCNT_W'(1);
  assign mck_en = &(pcnt_q | ~mask);
  assign tick_o = run_i && mck_en && (dcnt_q == div_i);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pcnt_q <= '0;
    end else if (!run_i) begin
      pcnt_q <= '0;
    end else begin
      pcnt_q <= pcnt_q + PCNT_W'(1);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dcnt_q <= '0;
    end else if (!run_i || tick_o) begin
      dcnt_q <= '0;
    end else if (mck_en) begin
      dcnt_q <= dcnt_q + DIV_W'(1);
    end
  end

endmodule : ssp_clk_div

// ### ssp_spi_master.sv
// simplified spi master full-duplex channel with axi4-lite registers
`timescale 1ns/1ps
// Overview of operation
// - irq at transfer end or at buffer empty, per irq_source_sel.
// - sck at most fclk/2 first channel, fclk/4 others; min fclk/(2*2^15*128).
// - data phase 0 starts data with first edge; 1 starts half period earlier.
// - clock_polarity_sel 0 keeps serial clock normal, 1 inverts it.
// - data write while buffer_full_flag set overwrites buffered transmit data.
// - reading data during transfer returns pending transmit data, shift untouched.
// - irq_source_sel may change while running, before the final last bit.
// - writing data_low_byte starts a transfer driving data and clock lines.
// - transfer clock divides operation clock by divider in data upper bits.
// - writing 1 to start_trigger_bit sets channel_enabled_status and starts.
// - host masks irq, writes stop_trigger_bit; channel then halts.
// - overrun is the only error the channel detects.
module ssp_spi_master #(
  parameter int unsigned PRE_W = 4,
  parameter int unsigned DIV_W = 7,
  parameter bit FIRST_CH = 1'b1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // axi4-lite write address, data and response
  input wire logic [ssp_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [ssp_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // serial pins
  output logic serial_clock_line_o,
  output logic serial_clock_oe_o,
  output logic data_out_line_o,
  output logic data_out_oe_o,
  input wire logic data_in_line_i,
  // channel event
  output logic channel_irq_o
);

  localparam int unsigned DATA_HI = ssp_pkg::DATA_DIV_LSB + DIV_W - 1;

  function automatic logic hit(input logic [ssp_pkg::ADDR_W-1:0] a,
                               input logic [5:0] off);
    hit = (a[ssp_pkg::ADDR_W-1:2] == off[5:2]);
  endfunction : hit

  // position of the i-th transmitted bit inside the byte
  function automatic logic [2:0] bit_pos(input logic [2:0] i, input ssp_pkg::ssp_cfg_s c);
    logic [3:0] len;
    len = c.len8 ? ssp_pkg::LEN_LONG : ssp_pkg::LEN_SHORT;
    bit_pos = c.lsb_first ? i : 3'(len - 4'(i) - 4'h1);
  endfunction : bit_pos

  // axi write and read channel state
  logic aw_q, w_q, bvalid_q, rvalid_q;
  logic [ssp_pkg::ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic wr_fire, rd_fire;

  // registers
  ssp_pkg::ssp_cfg_s cfg_q;
  logic irq_sel_q, oe_q, en_q;
  logic [1:0] lvl_q;
  logic [DIV_W-1:0] div_q;
  logic [PRE_W-1:0] pre_q;
  logic [7:0] tx_buf_q, tx_sh_q, rx_buf_q, rx_sh_q;
  logic bff_q, rx_unread_q, ovf_q;

  // engine
  ssp_pkg::ssp_state_e st_q;
  logic [3:0] half_q;
  logic sck_q, so_q, irq_q, sck_pin_q, so_pin_q;
  logic si_meta_q, si_q;
  logic tick, busy, load, done, even;
  logic [2:0] idx, nidx;
  logic [3:0] half_last;
  logic [7:0] rx_next;
  logic [DIV_W-1:0] div_eff;

  assign s_axi_awready = !aw_q && !bvalid_q;
  assign s_axi_wready = !w_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign wr_fire = aw_q && w_q && !bvalid_q;
  assign rd_fire = s_axi_arvalid && !rvalid_q;

  // address and data may arrive in either order
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= ssp_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= (awaddr_q <= ssp_pkg::OFF_PRESC && !hit(awaddr_q, ssp_pkg::OFF_STAT))
                   ? ssp_pkg::RESP_OKAY : ssp_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // read answer one cycle after the address is taken
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= ssp_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rresp_q <= ssp_pkg::RESP_OKAY;
      rdata_q <= '0;
      if (hit(s_axi_araddr, ssp_pkg::OFF_DATA)) begin
        rdata_q[DATA_HI:ssp_pkg::DATA_DIV_LSB] <= div_q;
        rdata_q[7:0] <= (busy && bff_q) ? tx_buf_q : rx_buf_q;
      end else if (hit(s_axi_araddr, ssp_pkg::OFF_MODE)) begin
        rdata_q[0] <= irq_sel_q;
      end else if (hit(s_axi_araddr, ssp_pkg::OFF_COMM)) begin
        rdata_q[3:0] <= cfg_q;
      end else if (hit(s_axi_araddr, ssp_pkg::OFF_STAT)) begin
        rdata_q[ssp_pkg::STAT_OVF] <= ovf_q;
        rdata_q[ssp_pkg::STAT_BFF] <= bff_q;
        rdata_q[ssp_pkg::STAT_BUSY] <= busy;
      end else if (hit(s_axi_araddr, ssp_pkg::OFF_START)) begin
        rdata_q[0] <= en_q;
      end else if (hit(s_axi_araddr, ssp_pkg::OFF_OUTEN)) begin
        rdata_q[0] <= oe_q;
      end else if (hit(s_axi_araddr, ssp_pkg::OFF_OLVL)) begin
        rdata_q[1:0] <= lvl_q;
      end else if (hit(s_axi_araddr, ssp_pkg::OFF_PRESC)) begin
        rdata_q[PRE_W-1:0] <= pre_q;
      end else if (!hit(s_axi_araddr, ssp_pkg::OFF_FCLR)
                   && !hit(s_axi_araddr, ssp_pkg::OFF_STOP)) begin
        rresp_q <= ssp_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // configuration registers; writable whether busy or idle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_q <= ssp_pkg::CFG_RST;
      irq_sel_q <= 1'b0;
      oe_q <= 1'b0;
      lvl_q <= {ssp_pkg::OLVL_CLK_RST, ssp_pkg::OLVL_DATA_RST};
      div_q <= '0;
      pre_q <= '0;
    end else if (wr_fire && wstrb_q[0]) begin
      if (hit(awaddr_q, ssp_pkg::OFF_MODE)) begin
        irq_sel_q <= wdata_q[0];
      end
      if (hit(awaddr_q, ssp_pkg::OFF_COMM)) begin
        cfg_q <= wdata_q[3:0];
      end
      if (hit(awaddr_q, ssp_pkg::OFF_OUTEN)) begin
        oe_q <= wdata_q[0];
      end
      if (hit(awaddr_q, ssp_pkg::OFF_OLVL)) begin
        lvl_q <= wdata_q[1:0];
      end
      if (hit(awaddr_q, ssp_pkg::OFF_PRESC)) begin
        pre_q <= wdata_q[PRE_W-1:0];
      end
    end else if (wr_fire && wstrb_q[1] && hit(awaddr_q, ssp_pkg::OFF_DATA)) begin
      div_q <= wdata_q[DATA_HI:ssp_pkg::DATA_DIV_LSB];
    end
  end

  // other channels need at least two system clocks per half period
  assign div_eff = (!FIRST_CH && pre_q == '0 && div_q == '0) ? DIV_W'(1) : div_q;

  ssp_clk_div #(
    .PRE_W(PRE_W),
    .DIV_W(DIV_W)
  ) u_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(busy),
    .presc_i(pre_q),
    .div_i(div_eff),
    .tick_o(tick)
  );

  // data input is a pin, so it is synchronised first
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      si_meta_q <= 1'b0;
      si_q <= 1'b0;
    end else begin
      si_meta_q <= data_in_line_i;
      si_q <= si_meta_q;
    end
  end

  assign busy = (st_q != ssp_pkg::ST_IDLE);
  assign load = !busy && en_q && bff_q;
  assign even = !half_q[0];
  assign idx = bit_pos(half_q[3:1], cfg_q);
  assign nidx = bit_pos(3'(half_q[3:1] + 3'h1), cfg_q);
  assign half_last = cfg_q.len8 ? 4'(2 * ssp_pkg::LEN_LONG - 1) : 4'(2 * ssp_pkg::LEN_SHORT - 1);
  assign done = (st_q == ssp_pkg::ST_SHIFT) && tick && (half_q == half_last);

  // sample on the falling half with data phase 1, else on the rising half
  always_comb begin
    rx_next = rx_sh_q;
    if (tick && st_q == ssp_pkg::ST_SHIFT && (even == cfg_q.data_phase_sel)) begin
      rx_next[idx] = si_q;
    end
  end

  // enable and buffer: start, stop and data writes
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      en_q <= 1'b0;
      bff_q <= 1'b0;
      tx_buf_q <= ssp_pkg::DATA_RST;
    end else begin
      if (load) begin
        bff_q <= 1'b0;
      end
      if (wr_fire && wstrb_q[0]) begin
        if (hit(awaddr_q, ssp_pkg::OFF_START) && wdata_q[0]) begin
          en_q <= 1'b1;
        end
        if (hit(awaddr_q, ssp_pkg::OFF_STOP) && wdata_q[0]) begin
          en_q <= 1'b0;
          bff_q <= 1'b0;
        end
        if (hit(awaddr_q, ssp_pkg::OFF_DATA)) begin
          tx_buf_q <= wdata_q[7:0];
          bff_q <= 1'b1;
        end
      end
    end
  end

  // shift engine
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= ssp_pkg::ST_IDLE;
      half_q <= '0;
      tx_sh_q <= ssp_pkg::DATA_RST;
      rx_sh_q <= ssp_pkg::DATA_RST;
      sck_q <= ssp_pkg::SCK_IDLE;
      so_q <= ssp_pkg::OLVL_DATA_RST;
    end else if (wr_fire && wstrb_q[0] && hit(awaddr_q, ssp_pkg::OFF_STOP) && wdata_q[0]) begin
      st_q <= ssp_pkg::ST_IDLE;
      sck_q <= ssp_pkg::SCK_IDLE;
    end else if (wr_fire && wstrb_q[0] && hit(awaddr_q, ssp_pkg::OFF_OLVL) && !busy) begin
      so_q <= wdata_q[ssp_pkg::OLVL_DATA];
    end else begin
      unique case (st_q)
        ssp_pkg::ST_IDLE: begin
          if (load) begin
            tx_sh_q <= tx_buf_q;
            half_q <= '0;
            rx_sh_q <= '0;
            if (cfg_q.data_phase_sel) begin
              so_q <= tx_buf_q[bit_pos(3'h0, cfg_q)];
              st_q <= ssp_pkg::ST_LEAD;
            end else begin
              st_q <= ssp_pkg::ST_SHIFT;
            end
          end
        end
        ssp_pkg::ST_LEAD: begin
          if (tick) begin
            st_q <= ssp_pkg::ST_SHIFT;
          end
        end
        ssp_pkg::ST_SHIFT: begin
          if (tick) begin
            rx_sh_q <= rx_next;
            sck_q <= !even;
            half_q <= half_q + 4'h1;
            if (even && !cfg_q.data_phase_sel) begin
              so_q <= tx_sh_q[idx];
            end
            if (!even && cfg_q.data_phase_sel && !done) begin
              so_q <= tx_sh_q[nidx];
            end
            if (done) begin
              st_q <= ssp_pkg::ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // receive buffer, overrun and the channel event
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_buf_q <= ssp_pkg::DATA_RST;
      rx_unread_q <= 1'b0;
      ovf_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      irq_q <= (load && irq_sel_q) || (done && !irq_sel_q);
      if (rd_fire && hit(s_axi_araddr, ssp_pkg::OFF_DATA) && !(busy && bff_q)) begin
        rx_unread_q <= 1'b0;
      end
      if (wr_fire && wstrb_q[0] && hit(awaddr_q, ssp_pkg::OFF_FCLR)
          && wdata_q[ssp_pkg::STAT_OVF]) begin
        ovf_q <= 1'b0;
      end
      // a completion in the clear cycle still counts
      if (done) begin
        rx_buf_q <= rx_next;
        rx_unread_q <= 1'b1;
        if (rx_unread_q) begin
          ovf_q <= 1'b1;
        end
      end
    end
  end

  // pins are registered; disabled output shows the programmed idle levels
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sck_pin_q <= ssp_pkg::OLVL_CLK_RST;
      so_pin_q <= ssp_pkg::OLVL_DATA_RST;
    end else begin
      sck_pin_q <= (oe_q && busy) ? (sck_q ^ cfg_q.clock_polarity_sel)
                                  : lvl_q[ssp_pkg::OLVL_CLK];
      so_pin_q <= oe_q ? so_q : lvl_q[ssp_pkg::OLVL_DATA];
    end
  end

  assign serial_clock_line_o = sck_pin_q;
  assign data_out_line_o = so_pin_q;
  assign serial_clock_oe_o = oe_q;
  assign data_out_oe_o = oe_q;
  assign channel_irq_o = irq_q;

endmodule : ssp_spi_master

// ### ssp_monitor.sv
// concurrent checks on the spi master channel ports
`timescale 1ns/1ps
module ssp_monitor #(
  parameter bit FIRST_CH = 1'b1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // axi handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // serial pins and event
  input wire logic serial_clock_line_o,
  input wire logic serial_clock_oe_o,
  input wire logic data_out_oe_o,
  input wire logic channel_irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  a_wr_answer_due: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_rd_answer_due: assert property (s_rd_taken |-> ##[1:2] s_axi_rvalid)
    else $error("read response late");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_rresp_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read response dropped");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  a_irq_one_pulse: assert property (channel_irq_o |=> !channel_irq_o)
    else $error("irq longer than one cycle");
  a_oe_paired: assert property (data_out_oe_o == serial_clock_oe_o)
    else $error("data and clock enables differ");
  // other channels may not toggle the clock on two adjacent cycles
  a_sck_rate_cap: assert property (!FIRST_CH && serial_clock_oe_o && $changed(serial_clock_line_o)
    |=> $stable(serial_clock_line_o))
    else $error("serial clock too fast");
endmodule : ssp_monitor

bind ssp_spi_master ssp_monitor #(.FIRST_CH(FIRST_CH)) ssp_monitor_i (.clk_i, .rst_i,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .serial_clock_line_o,
  .serial_clock_oe_o, .data_out_oe_o, .channel_irq_o);

// ### ssp_slave_model.sv
// far-side slave model: echoes the master data line back
`timescale 1ns/1ps
module ssp_slave_model (
  // clock
  input wire logic clk_i,
  // pins from the master, and the bench's slow-echo select
  input wire logic oe_i,
  input wire logic sdo_i,
  input wire logic slow_i,
  // pin to the master
  output logic sdi_o
);
  logic echo_q;
  initial begin
    sdi_o = 1'h0;
    echo_q = 1'h0;
  end
  // released line toggles so a stale bit never passes for data
  always @(posedge clk_i) begin
    echo_q <= sdo_i;
    if (!oe_i) begin
      sdi_o <= ~sdi_o;
    end else begin
      sdi_o <= slow_i ? echo_q : sdo_i;
    end
  end
endmodule : ssp_slave_model

// ### spi_master_full_duplex_tb_top.sv
// self-checking bench for the spi master channel
`timescale 1ns/1ps
module spi_master_full_duplex_tb_top;
  logic clk_i, rst_i, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [ssp_pkg::ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat, cfg, tx, d3;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic serial_clock_line_o, serial_clock_oe_o, data_out_line_o, data_out_oe_o;
  logic data_in_line_i, channel_irq_o, slow, sck_prev;
  int err_total, n_compared, seed, irq_cnt, sck_cnt, b, i;

  ssp_spi_master #(.FIRST_CH(1'h0)) ssp_spi_master_i (.clk_i, .rst_i, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .serial_clock_line_o,
    .serial_clock_oe_o, .data_out_line_o, .data_out_oe_o, .data_in_line_i, .channel_irq_o);
  ssp_slave_model ssp_slave_model_i (.clk_i, .oe_i(data_out_oe_o), .sdo_i(data_out_line_o),
    .slow_i(slow), .sdi_o(data_in_line_i));

  initial begin
    clk_i = 1'h0;
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    sck_prev <= serial_clock_line_o;
    if (channel_irq_o === 1'h1) irq_cnt <= irq_cnt + 1;
    if (serial_clock_line_o !== sck_prev) sck_cnt <= sck_cnt + 1;
  end

  function automatic logic [31:0] exp_edges(input logic [31:0] c);
    return c[ssp_pkg::COMM_LEN8] ? 32'h10 : 32'he;
  endfunction : exp_edges
  // a 7-bit frame never writes the top received bit
  function automatic logic [31:0] rx_mask(input logic [31:0] c);
    return c[ssp_pkg::COMM_LEN8] ? 32'hff : 32'h7f;
  endfunction : rx_mask
  task automatic mm(input string m);
    err_total++;
    $display("mismatch at %0t: %s", $time, m);
  endtask : mm
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) mm(m);
  endtask : chk
  task automatic axi_wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    logic ad, wd, bd;
    int n;
    ad = 1'h0; wd = 1'h0; bd = 1'h0; n = 0;
    @(posedge clk_i);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1; s_axi_wvalid <= 1'h1;
    while (!bd && n < 100) begin
      @(negedge clk_i);
      n++;
      if (s_axi_awvalid && s_axi_awready) ad = 1'h1;
      if (s_axi_wvalid && s_axi_wready) wd = 1'h1;
      if (s_axi_bvalid && s_axi_bready) begin
        bd = 1'h1;
        rsp = s_axi_bresp;
      end
      @(posedge clk_i);
      if (ad) s_axi_awvalid <= 1'h0;
      if (wd) s_axi_wvalid <= 1'h0;
      // late ready exercises the held response
      s_axi_bready <= !bd && n > 2;
    end
    if (!bd) mm("write hang");
  endtask : axi_wr
  task automatic axi_rd(input logic [5:0] a);
    logic ad, bd;
    int n;
    ad = 1'h0; bd = 1'h0; n = 0;
    @(posedge clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    while (!bd && n < 100) begin
      @(negedge clk_i);
      n++;
      if (s_axi_arvalid && s_axi_arready) ad = 1'h1;
      if (s_axi_rvalid && s_axi_rready) begin
        bd = 1'h1;
        rdat = s_axi_rdata;
        rsp = s_axi_rresp;
      end
      @(posedge clk_i);
      if (ad) s_axi_arvalid <= 1'h0;
      s_axi_rready <= !bd && n > 1;
    end
    if (!bd) mm("read hang");
  endtask : axi_rd
  task automatic wait_irq(input int base);
    int k;
    k = 0;
    while (irq_cnt == base && k < 3000) begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 3000) mm("irq missing");
  endtask : wait_irq
  task automatic close_out;
    if (err_total == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out

  // whole run needs well under 40 us
  initial begin
    #200us;
    mm("watchdog");
    close_out();
  end

  initial begin
    seed = 67; err_total = 0; n_compared = 0; irq_cnt = 0; sck_cnt = 0; slow = 1'h0;
    rst_i = 1'h1; s_axi_awaddr = '0; s_axi_araddr = '0; s_axi_wdata = '0; s_axi_wstrb = '0;
    s_axi_awvalid = 1'h0; s_axi_wvalid = 1'h0; s_axi_bready = 1'h0;
    s_axi_arvalid = 1'h0; s_axi_rready = 1'h0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'h0;
    axi_rd(ssp_pkg::OFF_COMM); chk(rdat, 32'h8, "comm reset");
    axi_rd(ssp_pkg::OFF_OLVL); chk(rdat, 32'h3, "level reset");
    axi_rd(6'h3c); chk({rdat[29:0], rsp}, {30'h0, ssp_pkg::RESP_SLVERR}, "unmapped");
    axi_wr(ssp_pkg::OFF_STAT, 32'h1); chk({30'h0, rsp}, 32'h2, "status write");
    axi_wr(ssp_pkg::OFF_DATA, 32'h7 << ssp_pkg::DATA_DIV_LSB, 4'h2);
    axi_wr(ssp_pkg::OFF_START, 32'h1);
    axi_rd(ssp_pkg::OFF_START); chk(rdat & 32'h1, 32'h1, "enable");
    for (i = 0; i < 8; i++) begin
      cfg = (i < 2) ? {28'h0, {4{i[0]}}} : $random(seed) & 32'hf;
      tx = $random(seed) & 32'hff;
      slow <= i[1];
      axi_wr(ssp_pkg::OFF_OUTEN, 32'h0);
      axi_wr(ssp_pkg::OFF_COMM, cfg);
      axi_wr(ssp_pkg::OFF_OLVL, {30'h0, ~cfg[ssp_pkg::COMM_CKP], 1'h1});
      chk({29'h0, data_out_oe_o, serial_clock_line_o, data_out_line_o},
          {29'h0, 1'h0, ~cfg[ssp_pkg::COMM_CKP], 1'h1}, "idle levels");
      axi_wr(ssp_pkg::OFF_OUTEN, 32'h1);
      b = sck_cnt;
      axi_wr(ssp_pkg::OFF_DATA, tx, 4'h1);
      wait_irq(irq_cnt);
      repeat (8) @(posedge clk_i);
      chk(32'(sck_cnt - b), exp_edges(cfg), "clock edges");
      axi_rd(ssp_pkg::OFF_DATA);
      chk(rdat & 32'hff, tx & rx_mask(cfg), "echo");
      axi_rd(ssp_pkg::OFF_STAT); chk(rdat & 32'h61, 32'h0, "idle status");
    end
    // continuous mode with overwrite, then overrun
    tx = $random(seed) & 32'hff;
    d3 = $random(seed) & 32'hff;
    axi_wr(ssp_pkg::OFF_MODE, 32'h1);
    b = irq_cnt;
    axi_wr(ssp_pkg::OFF_DATA, tx, 4'h1);
    wait_irq(b);
    axi_wr(ssp_pkg::OFF_DATA, ~tx & 32'hff, 4'h1);
    axi_wr(ssp_pkg::OFF_DATA, d3, 4'h1);
    axi_rd(ssp_pkg::OFF_DATA); chk(rdat & 32'hff, d3, "pending data");
    b = irq_cnt;
    axi_wr(ssp_pkg::OFF_MODE, 32'h0);
    wait_irq(b);
    b = irq_cnt;
    wait_irq(b);
    repeat (8) @(posedge clk_i);
    axi_rd(ssp_pkg::OFF_STAT); chk(rdat & 32'h1, 32'h1, "overrun");
    axi_rd(ssp_pkg::OFF_DATA); chk(rdat & 32'hff, d3 & rx_mask(cfg), "last echo");
    axi_wr(ssp_pkg::OFF_FCLR, 32'h1);
    axi_rd(ssp_pkg::OFF_STAT); chk(rdat & 32'h1, 32'h0, "overrun clear");
    // stop in mid-frame
    axi_wr(ssp_pkg::OFF_DATA, tx, 4'h1);
    repeat (20) @(posedge clk_i);
    axi_wr(ssp_pkg::OFF_STOP, 32'h1);
    repeat (4) @(posedge clk_i);
    b = sck_cnt;
    repeat (200) @(posedge clk_i);
    chk(32'(sck_cnt - b), 32'h0, "halted clock");
    axi_rd(ssp_pkg::OFF_START); chk(rdat & 32'h1, 32'h0, "disabled");
    close_out();
  end
endmodule : spi_master_full_duplex_tb_top
